//--- tb/pci_pin_change_assertions.sv
// checker on the ports of the pin change block
// assumes it is bound into pci_pin_change, one clock domain
`timescale 1ns/1ps
module pci_chk
    import pci_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AddrWidth-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PinCount-1:0] outData,
    input wire logic [PinCount-1:0] outEnable,
    input wire logic [PinCount-1:0] padOut,
    input wire logic [PinCount-1:0] padOe,
    input wire logic irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic arFire;
    logic woAddr;
    logic badAddr;
    assign arFire = s_axi_arvalid && s_axi_arready;
    assign woAddr = s_axi_araddr[7:5] == 3'h2 && !s_axi_araddr[3];
    assign badAddr = s_axi_araddr[7:6] != 2'h1 || s_axi_araddr[5:2] > 4'h6;
    // one formula fits both modes, since open-drain bits hold padOut at 0
    AST_PAD_OE: assert property (!$past(srst) |->
        padOe == ($past(outEnable) & ~(padOut ^ $past(outData))))
        else $error("pad enable wrong");
    AST_RST_IRQ: assert property ($fell(srst) |-> !irqOut [*3])
        else $error("irq high after reset");
    AST_RD_LAT: assert property (arFire |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer not released");
    AST_AR_HOLD: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    AST_WO_READ: assert property (arFire && woAddr |=>
        s_axi_rdata == '0 && s_axi_rresp == RespOkay)
        else $error("write-only register read not zero");
    AST_BAD_READ: assert property (arFire && badAddr |=>
        s_axi_rdata == '0 && s_axi_rresp == RespSlvErr)
        else $error("unmapped read not refused");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write answer not released");
    COV_IRQ: cover property ($rose(irqOut));
    COV_FLAGS: cover property (arFire && s_axi_araddr == OffChangeFlags);
    COV_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pci_chk
bind pci_pin_change pci_chk u_chk (.*);

//--- tb/pci_pin_change_test.sv
// bench for the pin change block: axi-lite tasks and pin stimulus
// assumes pins come from pci_pin_model with pull-ups
`timescale 1ns/1ps
module pci_pin_change_test
    import pci_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, outData = 32'h0, outEnable = 32'h0;
    logic [31:0] extLow = 32'h0, s_axi_rdata, padOut, padOe, pinLevel;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irqOut;
    int errorCnt = 0, numChecks = 0;
    always #2 clk = ~clk;
    pci_pin_change DUT (.*);
    pci_pin_model u_pins (.*);
    task automatic chk(input string n, input logic [31:0] s, e);
        numChecks++;
        if (s !== e) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        chk("bresp", 32'(s_axi_bresp), 32'(r));
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    task automatic results();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(OffIrqMaskView, MaskReset);
        rd(OffOpenDrainView, OpenDrainReset);
        rd(OffChangeFlags, FlagsReset);
        rd(OffIrqEnableSet, 32'h0);
        rd(8'h5C, 32'h0, RespSlvErr);
        wr(OffIrqMaskView, 32'hFFFF_FFFF, RespSlvErr);
        wr(OffIrqEnableSet, 32'hF0);
        wr(OffIrqEnableSet, 32'h0);
        rd(OffIrqMaskView, 32'hF0);
        wr(OffIrqEnableClear, 32'h30);
        rd(OffIrqMaskView, 32'hC0);
        extLow <= 32'h11;
        repeat (6) @(posedge clk);
        chk("irq", 32'(irqOut), 32'h0);
        rd(OffChangeFlags, 32'h11);
        rd(OffChangeFlags, 32'h0);
        // bit 6 pulses low and back: one flag for two edges
        extLow <= 32'h40;
        repeat (2) @(posedge clk);
        extLow <= 32'h0;
        repeat (6) @(posedge clk);
        chk("irq", 32'(irqOut), 32'h1);
        rd(OffChangeFlags, 32'h51);
        repeat (3) @(posedge clk);
        chk("irq", 32'(irqOut), 32'h0);
        outEnable <= 32'h100;
        outData <= 32'h100;
        repeat (6) @(posedge clk);
        rd(OffChangeFlags, 32'h0);
        outData <= 32'h0;
        repeat (6) @(posedge clk);
        rd(OffChangeFlags, 32'h100);
        wr(OffOpenDrainSet, 32'h100);
        rd(OffOpenDrainView, 32'h100);
        outData <= 32'h100;
        repeat (6) @(posedge clk);
        chk("padOe", padOe, 32'h0);
        chk("pin", pinLevel, 32'hFFFF_FFFF);
        rd(OffChangeFlags, 32'h100);
        wr(OffOpenDrainClear, 32'h100);
        rd(OffOpenDrainView, 32'h0);
        repeat (2) @(posedge clk);
        chk("padOut", padOut, 32'h100);
        chk("padOe", padOe, 32'h100);
        results();
    end
    // the run needs some 120 cycles; 4000 cycles means a hang
    initial begin
        repeat (4000) @(posedge clk);
        errorCnt++;
        results();
    end
endmodule // pci_pin_change_test

//--- tb/pci_pin_model.sv
// pin model: pull-up lines shared with other open-drain drivers
// assumes padOe high means the block drives the pin
`timescale 1ns/1ps
module pci_pin_model
    import pci_pkg::*;
(
    input wire logic [PinCount-1:0] padOut,
    input wire logic [PinCount-1:0] padOe,
    input wire logic [PinCount-1:0] extLow,
    output logic [PinCount-1:0] pinLevel
);
    // any low driver wins; a released line floats up to one
    assign pinLevel = ~((padOe & ~padOut) | extLow);
endmodule // pci_pin_model

//--- verilog/pci_pin_change.sv
// pin change detector, interrupt mask and open-drain control for 32 pins
// assumes pin levels arrive asynchronously; outputs feed the pad ring
//
// Contract
// - writing one to enable-set enables that pin's change interrupt
// - enable and disable act whether or not the pin is parallel io
// - enable-clear disables interrupt; change detection keeps recording
// - mask view reads enabled pins, resets zero, follows set/clear writes
// - any rising or falling edge sets the pin's change flag
// - detection works for any pin owner and any direction
// - change flags clear when read and are zero after reset
// - a set flag stays set until the next read
// - writing one to open-drain set makes that pin's driver open-drain
// - writing one to open-drain clear returns the pin to push-pull
// - open-drain view reads configured pins, zero after reset
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pci_pin_change
    import pci_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [AddrWidth-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AddrWidth-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PinCount-1:0] pinLevel,
    input wire logic [PinCount-1:0] outData,
    input wire logic [PinCount-1:0] outEnable,
    output logic [PinCount-1:0] padOut,
    output logic [PinCount-1:0] padOe,
    output logic irqOut
);

    // ****************************************************************
    // pin synchroniser and edge detect
    // ****************************************************************
    logic [PinCount-1:0] pinMeta_q;
    logic [PinCount-1:0] pinSync_q;
    logic [PinCount-1:0] pinLast_q;
    logic [PinCount-1:0] pinEdge;
    logic primed_q;

    always_ff @(posedge clk) begin
        pinMeta_q <= pinLevel;
        pinSync_q <= pinMeta_q;
        pinLast_q <= pinSync_q;
    end

    // edges are masked during reset and for the first cycle after it
    always_ff @(posedge clk) begin
        if (srst) begin
            primed_q <= 1'b0;
        end else begin
            primed_q <= 1'b1;
        end
    end

    // raw pad level is used, so owner and direction do not matter
    assign pinEdge = primed_q ? (pinSync_q ^ pinLast_q) : '0;

    // ****************************************************************
    // write channel
    // ****************************************************************
    logic awHeld_q;
    logic wHeld_q;
    logic [AddrWidth-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic writeFire;
    logic writeHit;

    assign writeFire = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            s_axi_awready <= 1'b0;
        end else if (writeFire) begin
            awHeld_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_q && !s_axi_bvalid;
        end
    end

    // strobes are ignored: set and clear words act on whole words
    always_ff @(posedge clk) begin
        if (srst) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            s_axi_wready <= 1'b0;
        end else if (writeFire) begin
            wHeld_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !wHeld_q && !s_axi_bvalid;
        end
    end

    always_comb begin
        unique case (awAddr_q[7:2])
            OffIrqEnableSet[7:2],
            OffIrqEnableClear[7:2],
            OffOpenDrainSet[7:2],
            OffOpenDrainClear[7:2]: writeHit = 1'b1;
            default: writeHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RespOkay;
        end else if (writeFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? RespOkay : RespSlvErr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // interrupt mask and open-drain configuration
    // ****************************************************************
    logic [PinCount-1:0] irqMask_q;
    logic [PinCount-1:0] openDrain_q;
    logic [PinCount-1:0] flags_q;
    logic wrEnSet;
    logic wrEnClr;
    logic wrOdSet;
    logic wrOdClr;

    assign wrEnSet = writeFire && awAddr_q[7:2] == OffIrqEnableSet[7:2];
    assign wrEnClr = writeFire && awAddr_q[7:2] == OffIrqEnableClear[7:2];
    assign wrOdSet = writeFire && awAddr_q[7:2] == OffOpenDrainSet[7:2];
    assign wrOdClr = writeFire && awAddr_q[7:2] == OffOpenDrainClear[7:2];

    // no pin-owner term gates these writes
    always_ff @(posedge clk) begin
        if (srst) begin
            irqMask_q <= MaskReset;
        end else if (wrEnSet) begin
            irqMask_q <= irqMask_q | wData_q;
        end else if (wrEnClr) begin
            irqMask_q <= irqMask_q & ~wData_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            openDrain_q <= OpenDrainReset;
        end else if (wrOdSet) begin
            openDrain_q <= openDrain_q | wData_q;
        end else if (wrOdClr) begin
            openDrain_q <= openDrain_q & ~wData_q;
        end
    end

    // ****************************************************************
    // read channel and change flags
    // ****************************************************************
    logic readFire;
    logic readHit;
    logic flagsRead;
    logic [31:0] readWord;

    assign readFire = s_axi_arvalid && s_axi_arready;
    assign flagsRead = readFire && s_axi_araddr[7:2] == OffChangeFlags[7:2];

    always_comb begin
        readHit = 1'b1;
        unique case (s_axi_araddr[7:2])
            OffIrqMaskView[7:2]: readWord = irqMask_q;
            OffChangeFlags[7:2]: readWord = flags_q;
            OffOpenDrainView[7:2]: readWord = openDrain_q;
            OffIrqEnableSet[7:2],
            OffIrqEnableClear[7:2],
            OffOpenDrainSet[7:2],
            OffOpenDrainClear[7:2]: readWord = '0;
            default: begin
                readWord = '0;
                readHit = 1'b0;
            end
        endcase
    end

    // detection ignores the mask, so a disabled pin still records
    // a new edge beats the read clear, else the change would be lost
    for (genvar p = 0; p < PinCount; p++) begin : g_flag
        always_ff @(posedge clk) begin
            if (srst) begin
                flags_q[p] <= FlagsReset[p];
            end else if (pinEdge[p]) begin
                flags_q[p] <= 1'b1;
            end else if (flagsRead) begin
                flags_q[p] <= 1'b0;
            end
        end
    end

    // read answer travels as one word plus response code
    pci_rd_t readAns_q;

    assign s_axi_rdata = readAns_q.data;
    assign s_axi_rresp = readAns_q.resp;

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            readAns_q.data <= '0;
            readAns_q.resp <= RespOkay;
        end else if (readFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            readAns_q.data <= readWord;
            readAns_q.resp <= readHit ? RespOkay : RespSlvErr;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // pad drive and interrupt output
    // ****************************************************************
    // open-drain pins only ever pull low; a high is left to the line
    // limitation: the line then rises only as fast as its pull-up allows
    for (genvar p = 0; p < PinCount; p++) begin : g_pad
        always_ff @(posedge clk) begin
            if (srst) begin
                padOut[p] <= 1'b0;
                padOe[p] <= 1'b0;
            end else if (openDrain_q[p]) begin
                padOut[p] <= 1'b0;
                padOe[p] <= outEnable[p] && !outData[p];
            end else begin
                padOut[p] <= outData[p];
                padOe[p] <= outEnable[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(flags_q & irqMask_q);
        end
    end

endmodule // pci_pin_change

//--- verilog/pci_pkg.sv
// package for the pin change interrupt and open-drain block
// assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock
package pci_pkg;
    localparam int PinCount = 32;
    localparam int AddrWidth = 8;
    localparam logic [7:0] OffIrqEnableSet = 8'h40;
    localparam logic [7:0] OffIrqEnableClear = 8'h44;
    localparam logic [7:0] OffIrqMaskView = 8'h48;
    localparam logic [7:0] OffChangeFlags = 8'h4C;
    localparam logic [7:0] OffOpenDrainSet = 8'h50;
    localparam logic [7:0] OffOpenDrainClear = 8'h54;
    localparam logic [7:0] OffOpenDrainView = 8'h58;
    localparam logic [31:0] MaskReset = 32'h0000_0000;
    localparam logic [31:0] OpenDrainReset = 32'h0000_0000;
    localparam logic [31:0] FlagsReset = 32'h0000_0000;
    localparam logic [1:0] RespOkay = 2'h0;
    localparam logic [1:0] RespSlvErr = 2'h2;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } pci_rd_t;
endpackage
